// [hdl/ssp_pkg.sv]
// Constants and carrier types for the synthesizer serial program port
package ssp_pkg;
    localparam int WORD_W = 22;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 4;
    localparam int NUM_REGS = 16;
    // Register addresses
    localparam logic [3:0] ADDR_MAIN_CFG = 4'h0;
    localparam logic [3:0] ADDR_POWER = 4'h2;
    localparam logic [3:0] ADDR_RF1_N = 4'h3;
    localparam logic [3:0] ADDR_RF2_N = 4'h4;
    localparam logic [3:0] ADDR_IF_N = 4'h5;
    localparam logic [3:0] ADDR_RF1_R = 4'h6;
    localparam logic [3:0] ADDR_RF2_R = 4'h7;
    localparam logic [3:0] ADDR_IF_R = 4'h8;
    // Field positions
    localparam int POS_RF_POWERUP = 0;
    localparam int POS_IF_POWERUP = 1;
    localparam int POS_IF_DIV_LO = 10;
    localparam int POS_IF_DIV_HI = 11;
    // Reset values
    localparam logic [17:0] REG_RESET = 18'h0_0000;
    localparam logic [1:0] IF_DIV_RESET = 2'h0;
    // Self-tuning length in phase-detector update periods
    localparam int TUNE_PERIODS = 13;
    localparam logic [3:0] TUNE_LAST = 4'(TUNE_PERIODS - 1);

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
    } ssp_word_t;

    typedef struct packed {
        logic valid;
        ssp_word_t word;
    } ssp_write_t;

    typedef enum logic [1:0] {
        SSP_PLL_OFF,
        SSP_PLL_TUNE,
        SSP_PLL_LOCK
    } ssp_pll_state_t;
endpackage

// [hdl/ssp_sync2.sv]
// Two-flop level synchroniser
`timescale 1ns/1ps
module ssp_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ssp_sync_state_t;

    ssp_sync_state_t st;
    ssp_sync_state_t next_st;

    always_comb
    begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st <= {RESET_VAL, RESET_VAL};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

// [hdl/ssp_port.sv]
// Serial program port: shift register, register file, RF select, tuning, IF divider
`timescale 1ns/1ps
module ssp_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_clk,
    input wire logic serial_enable_n,
    input wire logic serial_data_in,
    input wire logic powerdown_pin_n,
    input wire logic rf_update_tick,
    input wire logic if_update_tick,
    input wire logic if_vco_tick,
    output ssp_pkg::ssp_write_t reg_write,
    output logic rf2_selected,
    output logic rf_powered,
    output logic if_powered,
    output ssp_pkg::ssp_pll_state_t rf_state,
    output ssp_pkg::ssp_pll_state_t if_state,
    output logic [1:0] if_div_code,
    output logic if_out_tick
);
    ////////////////////////////////////////////////////////////////////////
    // Link domain: shift register on the serial clock
    typedef struct packed {
        logic [ssp_pkg::WORD_W-1:0] shreg;
    } ssp_link_state_t;

    ssp_link_state_t lk;
    ssp_link_state_t next_lk;

    always_comb
    begin
        next_lk = lk;
        if (!serial_enable_n)
        begin
            // Oldest bits fall off the top
            next_lk.shreg = {lk.shreg[ssp_pkg::WORD_W-2:0], serial_data_in};
        end
    end

    always_ff @(posedge serial_clk)
    begin
        lk <= next_lk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic enable_n_sync;
    logic pd_pin_n_sync;

    ssp_sync2 #(.RESET_VAL(1'b1)) u_sync_en (
        .clk(clk),
        .rst(rst),
        .d(serial_enable_n),
        .q(enable_n_sync)
    );

    ssp_sync2 #(.RESET_VAL(1'b1)) u_sync_pd (
        .clk(clk),
        .rst(rst),
        .d(powerdown_pin_n),
        .q(pd_pin_n_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // System domain state
    typedef struct packed {
        logic en_prev;
        ssp_pkg::ssp_write_t wr;
        logic [ssp_pkg::NUM_REGS-1:0][ssp_pkg::DATA_W-1:0] regs;
        logic rf2_sel;
        logic rf_on;
        logic if_on;
        ssp_pkg::ssp_pll_state_t rf_st;
        ssp_pkg::ssp_pll_state_t if_st;
        logic [3:0] rf_cnt;
        logic [3:0] if_cnt;
        logic [2:0] div_cnt;
        logic div_out;
    } ssp_sys_state_t;

    ssp_sys_state_t st;
    ssp_sys_state_t next_st;

    always_comb
    begin
        logic en_rise;
        logic [3:0] a;
        logic [17:0] d;
        logic rf_up_req;
        logic if_up_req;
        logic rf_freq;
        logic if_freq;
        logic pin_on;
        logic rf_want;
        logic if_want;
        logic [2:0] div_mask;
        en_rise = 1'b0;
        a = 4'h0;
        d = 18'h0_0000;
        rf_up_req = 1'b0;
        if_up_req = 1'b0;
        rf_freq = 1'b0;
        if_freq = 1'b0;
        pin_on = 1'b0;
        rf_want = 1'b0;
        if_want = 1'b0;
        div_mask = 3'h0;
        next_st = st;
        next_st.en_prev = enable_n_sync;
        next_st.wr.valid = 1'b0;

        // Shift register is frozen while enable is high, so safe to read here
        en_rise = enable_n_sync && !st.en_prev;
        a = lk.shreg[ssp_pkg::ADDR_W-1:0];
        d = lk.shreg[ssp_pkg::WORD_W-1:ssp_pkg::ADDR_W];
        if (en_rise)
        begin
            next_st.regs[a] = d;
            next_st.wr.valid = 1'b1;
            next_st.wr.word.addr = a;
            next_st.wr.word.data = d;
            unique case (a)
                ssp_pkg::ADDR_RF1_N, ssp_pkg::ADDR_RF1_R:
                begin
                    next_st.rf2_sel = 1'b0;
                    rf_freq = 1'b1;
                end
                ssp_pkg::ADDR_RF2_N, ssp_pkg::ADDR_RF2_R:
                begin
                    next_st.rf2_sel = 1'b1;
                    rf_freq = 1'b1;
                end
                ssp_pkg::ADDR_IF_N, ssp_pkg::ADDR_IF_R:
                begin
                    if_freq = 1'b1;
                end
                default:
                begin
                end
            endcase
        end

        // Effective power: pin high and register bit set
        pin_on = pd_pin_n_sync;
        rf_want = pin_on && next_st.regs[ssp_pkg::ADDR_POWER][ssp_pkg::POS_RF_POWERUP];
        if_want = pin_on && next_st.regs[ssp_pkg::ADDR_POWER][ssp_pkg::POS_IF_POWERUP];
        rf_up_req = rf_want && !st.rf_on;
        if_up_req = if_want && !st.if_on;
        next_st.rf_on = rf_want;
        next_st.if_on = if_want;

        // RF tuning sequencer
        if (!rf_want)
        begin
            next_st.rf_st = ssp_pkg::SSP_PLL_OFF;
        end
        else if (rf_up_req || rf_freq)
        begin
            next_st.rf_st = ssp_pkg::SSP_PLL_TUNE;
            next_st.rf_cnt = 4'h0;
        end
        else if (st.rf_st == ssp_pkg::SSP_PLL_TUNE && rf_update_tick)
        begin
            next_st.rf_cnt = st.rf_cnt + 4'h1;
            if (st.rf_cnt == ssp_pkg::TUNE_LAST)
            begin
                next_st.rf_st = ssp_pkg::SSP_PLL_LOCK;
            end
        end

        // IF tuning sequencer
        if (!if_want)
        begin
            next_st.if_st = ssp_pkg::SSP_PLL_OFF;
        end
        else if (if_up_req || if_freq)
        begin
            next_st.if_st = ssp_pkg::SSP_PLL_TUNE;
            next_st.if_cnt = 4'h0;
        end
        else if (st.if_st == ssp_pkg::SSP_PLL_TUNE && if_update_tick)
        begin
            next_st.if_cnt = st.if_cnt + 4'h1;
            if (st.if_cnt == ssp_pkg::TUNE_LAST)
            begin
                next_st.if_st = ssp_pkg::SSP_PLL_LOCK;
            end
        end

        // IF output divider: one output tick per 1, 2, 4 or 8 VCO ticks
        div_mask = 3'((4'h1 << st.regs[ssp_pkg::ADDR_MAIN_CFG][ssp_pkg::POS_IF_DIV_HI:ssp_pkg::POS_IF_DIV_LO]) - 4'h1);
        next_st.div_out = 1'b0;
        if (st.if_on && if_vco_tick)
        begin
            if ((st.div_cnt & div_mask) == div_mask)
            begin
                next_st.div_cnt = 3'h0;
                next_st.div_out = 1'b1;
            end
            else
            begin
                next_st.div_cnt = st.div_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st.en_prev <= 1'b1;
            st.wr <= '0;
            st.regs <= {ssp_pkg::NUM_REGS{ssp_pkg::REG_RESET}};
            st.rf2_sel <= 1'b0;
            st.rf_on <= 1'b0;
            st.if_on <= 1'b0;
            st.rf_st <= ssp_pkg::SSP_PLL_OFF;
            st.if_st <= ssp_pkg::SSP_PLL_OFF;
            st.rf_cnt <= 4'h0;
            st.if_cnt <= 4'h0;
            st.div_cnt <= 3'h0;
            st.div_out <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign reg_write = st.wr;
    assign rf2_selected = st.rf2_sel;
    assign rf_powered = st.rf_on;
    assign if_powered = st.if_on;
    assign rf_state = st.rf_st;
    assign if_state = st.if_st;
    assign if_div_code = st.regs[ssp_pkg::ADDR_MAIN_CFG][ssp_pkg::POS_IF_DIV_HI:ssp_pkg::POS_IF_DIV_LO];
    assign if_out_tick = st.div_out;
endmodule

// [tb/ssp_port_assertions.sv]
// Checker for the serial program port
`timescale 1ns/1ps
module ssp_port_assertions (
    input logic clk,
    input logic rst,
    input logic serial_enable_n,
    input logic powerdown_pin_n,
    input logic rf_update_tick,
    input ssp_pkg::ssp_write_t reg_write,
    input logic rf2_selected,
    input logic rf_powered,
    input logic if_powered,
    input ssp_pkg::ssp_pll_state_t rf_state,
    input logic if_out_tick
);
    logic [3:0] cnt;
    logic [3:0] a;
    logic tune;
    logic rf_wr;
    assign a = reg_write.word.addr;
    assign tune = rf_state == ssp_pkg::SSP_PLL_TUNE;
    // Frequency write to either RF PLL restarts the count
    assign rf_wr = reg_write.valid && (a == ssp_pkg::ADDR_RF1_N || a == ssp_pkg::ADDR_RF1_R
        || a == ssp_pkg::ADDR_RF2_N || a == ssp_pkg::ADDR_RF2_R);
    // Update ticks seen while tuning
    always_ff @(posedge clk)
        cnt <= (rst || !tune) ? 4'h0 : (rf_wr ? 4'(rf_update_tick) : cnt + 4'(rf_update_tick));
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_valid_pulse: assert property (reg_write.valid |=> !reg_write.valid) else $error("long valid");
    a_write_latency: assert property ($rose(serial_enable_n) |-> ##[2:5] reg_write.valid)
        else $error("no write");
    a_rf2_pick: assert property (reg_write.valid && (a == ssp_pkg::ADDR_RF2_N || a == ssp_pkg::ADDR_RF2_R)
        |-> ##[0:1] rf2_selected) else $error("rf2 not picked");
    a_rf1_pick: assert property (reg_write.valid && (a == ssp_pkg::ADDR_RF1_N || a == ssp_pkg::ADDR_RF1_R)
        |-> ##[0:1] !rf2_selected) else $error("rf1 not picked");
    a_powerup_tune: assert property ($rose(rf_powered) |-> ##[0:1] tune) else $error("no tune");
    a_pin_down: assert property ($fell(powerdown_pin_n) |-> ##[1:4] !rf_powered && !if_powered)
        else $error("still powered");
    a_off_state: assert property (!rf_powered && !$past(rf_powered) |-> rf_state == ssp_pkg::SSP_PLL_OFF)
        else $error("not off");
    a_tune_len: assert property (tune && rf_update_tick && cnt == 4'hC |=> rf_state == ssp_pkg::SSP_PLL_LOCK)
        else $error("no lock");
    a_out_gate: assert property (if_out_tick |-> $past(if_powered)) else $error("bad out");
endmodule
bind ssp_port ssp_port_assertions ssp_port_assertions_inst (.clk, .rst, .serial_enable_n, .powerdown_pin_n,
    .rf_update_tick, .reg_write, .rf2_selected, .rf_powered, .if_powered, .rf_state, .if_out_tick);

// [tb/ssp_host_model.sv]
// Host model driving the three-wire serial link
`timescale 1ns/1ps
module ssp_host_model (
    output logic serial_clk = 1'b0,
    output logic serial_enable_n = 1'b1,
    output logic serial_data_in = 1'b0
);
    // Low n bits of w, MSB first; quiet keeps the enable high
    task automatic send(input logic [29:0] w, input int n, input logic quiet);
        serial_enable_n = quiet;
        #200;
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_data_in = w[i];
            #16 serial_clk = 1'b1;
            #16 serial_clk = 1'b0;
        end
        #16 serial_enable_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #600;
    endtask
endmodule

// [tb/ssp_port_test.sv]
// Self-checking bench for the serial program port
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; $display("Error %0t %h %h", $time, a, e); end end
module ssp_port_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic powerdown_pin_n = 1'b1;
    logic rf_update_tick = 1'b0;
    logic if_update_tick = 1'b0;
    logic if_vco_tick = 1'b0;
    logic serial_clk, serial_enable_n, serial_data_in, rf2_selected, rf_powered, if_powered, if_out_tick;
    logic [1:0] if_div_code;
    ssp_pkg::ssp_write_t reg_write;
    ssp_pkg::ssp_pll_state_t rf_state, if_state;
    ssp_pkg::ssp_word_t last;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    int outs = 0;
    always #50 clk = ~clk;
    ssp_host_model ssp_host_model_inst (.serial_clk, .serial_enable_n, .serial_data_in);
    ssp_port ssp_port_inst (.clk, .rst, .serial_clk, .serial_enable_n, .serial_data_in, .powerdown_pin_n,
        .rf_update_tick, .if_update_tick, .if_vco_tick, .reg_write, .rf2_selected, .rf_powered, .if_powered,
        .rf_state, .if_state, .if_div_code, .if_out_tick);
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        rf_update_tick <= (cyc % 4 == 0);
        if_update_tick <= (cyc % 4 == 1);
        if (reg_write.valid === 1'b1)
            last <= reg_write.word;
        if (if_out_tick === 1'b1)
            outs <= outs + 1;
        if (cyc == 5000)
        begin
            error_cnt++;
            complete_run();
        end
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [17:0] d);
        ssp_host_model_inst.send({8'h00, d, a}, 22, 1'b0);
        `CHK(last, {d, a})
    endtask
    task automatic t_word();
        wr(ssp_pkg::ADDR_RF2_N, 18'h2_A5C3);
        `CHK(rf2_selected, 1'b1)
        wr(ssp_pkg::ADDR_RF1_R, 18'h1_0F0F);
        `CHK(rf2_selected, 1'b0)
        ssp_host_model_inst.send({8'hFF, 18'h3_1234, ssp_pkg::ADDR_IF_N}, 30, 1'b0);
        `CHK(last, {18'h3_1234, ssp_pkg::ADDR_IF_N})
        ssp_host_model_inst.send(30'h3FFF_FFFF, 10, 1'b1);
        ssp_host_model_inst.send(30'(ssp_pkg::ADDR_RF2_R), 4, 1'b0);
        `CHK(last, {18'h1_2345, ssp_pkg::ADDR_RF2_R})
        `CHK(rf2_selected, 1'b1)
        $display("t_word done");
    endtask
    task automatic t_power();
        wr(ssp_pkg::ADDR_POWER, 18'h0_0003);
        `CHK({rf_powered, if_powered, rf_state}, {2'b11, ssp_pkg::SSP_PLL_TUNE})
        w(70);
        `CHK({rf_state, if_state}, {ssp_pkg::SSP_PLL_LOCK, ssp_pkg::SSP_PLL_LOCK})
        wr(ssp_pkg::ADDR_RF1_N, 18'h0_0100);
        `CHK(rf_state, ssp_pkg::SSP_PLL_TUNE)
        w(70);
        powerdown_pin_n <= 1'b0;
        w(6);
        `CHK({rf_powered, if_powered, rf_state}, {2'b00, ssp_pkg::SSP_PLL_OFF})
        powerdown_pin_n <= 1'b1;
        w(6);
        `CHK(rf_state, ssp_pkg::SSP_PLL_TUNE)
        w(70);
        wr(ssp_pkg::ADDR_POWER, 18'h0_0002);
        `CHK({rf_powered, if_powered}, 2'b01)
        `CHK({rf_state, if_state}, {ssp_pkg::SSP_PLL_OFF, ssp_pkg::SSP_PLL_LOCK})
        wr(ssp_pkg::ADDR_IF_R, 18'h0_0040);
        `CHK(if_state, ssp_pkg::SSP_PLL_TUNE)
        $display("t_power done");
    endtask
    task automatic t_div();
        int base;
        for (int k = 0; k < 4; k++)
        begin
            wr(ssp_pkg::ADDR_MAIN_CFG, 18'(k) << 10);
            `CHK(if_div_code, 2'(k))
            base = outs;
            repeat (16)
            begin
                @(posedge clk) if_vco_tick <= 1'b1;
                @(posedge clk) if_vco_tick <= 1'b0;
            end
            w(4);
            `CHK(outs - base, 16 >> k)
        end
        $display("t_div done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        w(20);
        rst <= 1'b0;
        w(3);
        `CHK({reg_write, rf2_selected, rf_powered, if_powered, rf_state, if_state, if_div_code, if_out_tick}, 33'h0)
        t_word();
        t_power();
        t_div();
        complete_run();
    end
endmodule
